// ==== design/psw_top.sv ====
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
`include "psw_params.svh"
// Functional notes
// - Window read needs address MSB and enable
// - Window page forms upper program address bits
// - Window covers data addresses 0x8000 upward
// - Window read returns low 16 bits only
// - Window read stretched by one cycle
// - Table instructions suspend window access
// - Outside repeat: moves plus one, others plus two
// - Repeat edges plus two, middle iterations none
// - Rows of 64 words, pages of 512
// - Pages and rows aligned from memory start
// - Buffers loaded in order from one row
// - Table write completes in two cycles
// - Table address is page then effective address
// - Low instructions bits 15-0, high 23-16
// - Processor stalls during program or erase
// - Start bit launches, hardware clears at end
// - Duration counted in fast oscillator cycles
// - Key 0x55 then 0xAA before start
// - Write enable bit required for any operation
// - Error flag on bad attempt, cleared on success
// - Operation codes select erase, row, word

module psw_top #(
   parameter int ROW_OSC_CYCLES   = `PSW_ROW_OSC_CYCLES,
   parameter int ERASE_OSC_CYCLES = `PSW_ERASE_OSC_CYCLES,
   parameter int WORD_OSC_CYCLES  = `PSW_WORD_OSC_CYCLES
) (
   input  wire logic                     clock_i,
   input  wire logic                     rstn_i,
   input  wire logic                     psel_i,
   input  wire logic                     penable_i,
   input  wire logic                     pwrite_i,
   input  wire logic [`PSW_PADDR_W-1:0]  paddr_i,
   input  wire logic [31:0]              pwdata_i,
   output logic                          pready_o,
   output logic                          pslverr_o,
   output logic [31:0]                   prdata_o,
   input  wire psw_pkg::psw_win_req_t    win_req_i,
   input  wire psw_pkg::psw_tbl_req_t    tbl_req_i,
   input  wire logic [23:0]              pm_rdata_i,
   output logic                          pm_rd_o,
   output logic [23:0]                   pm_raddr_o,
   output logic                          win_valid_o,
   output logic [15:0]                   win_data_o,
   output logic [1:0]                    win_extra_o,
   output logic                          tbl_done_o,
   output logic [15:0]                   tbl_rdata_o,
   output logic                          stall_o,
   input  wire logic                     frc_clk_i,
   output logic                          fl_start_o,
   output psw_pkg::psw_fl_cmd_t          fl_cmd_o,
   input  wire logic [5:0]               fl_buf_idx_i,
   output logic [23:0]                   fl_buf_data_o,
   output logic                          fl_busy_o
);

   psw_pkg::psw_state_t       st_ff;
   psw_pkg::psw_state_t       nxt_st;
   logic                      tmr_done;
   logic [`PSW_OSC_CNT_W-1:0] tmr_count;
   logic                      acc_free;
   logic                      take_tbl;
   logic                      take_win;
   logic                      apb_setup_acc;
   logic                      apb_commit;
   logic                      addr_ok;
   logic                      op_valid;
   psw_pkg::psw_cmd_kind_t    op_kind;
   logic [15:0]               ctl_wdata;

   assign acc_free = (st_ff.acc == psw_pkg::PSW_ACC_IDLE) && (st_ff.fst == psw_pkg::PSW_FL_IDLE);
   assign take_tbl = acc_free && tbl_req_i.req;
   // Table request wins, so a window read never runs beside one
   assign take_win = acc_free && !tbl_req_i.req && win_req_i.req && st_ff.vis_en
                     && win_req_i.ea[`PSW_EA_MSB];
   assign apb_setup_acc = psel_i && penable_i && !st_ff.pready;
   assign apb_commit    = psel_i && penable_i && st_ff.pready && pwrite_i && !st_ff.pslverr;
   assign addr_ok = (paddr_i == `PSW_OFF_CORE_CTL) || (paddr_i == `PSW_OFF_WIN_PAGE)
                    || (paddr_i == `PSW_OFF_TBL_PAGE) || (paddr_i == `PSW_OFF_FL_CTL)
                    || (paddr_i == `PSW_OFF_FL_KEY);
   assign ctl_wdata = pwdata_i[15:0];

   // Operation decode on the value being written with the start bit
   always_comb begin
      op_valid = 1'b0;
      op_kind  = psw_pkg::PSW_CMD_PROG_ROW;
      if (ctl_wdata[`PSW_ERASE_BIT]) begin
         if (ctl_wdata[3:0] == `PSW_OP_PAGE_ERASE) begin
            op_valid = 1'b1;
            op_kind  = psw_pkg::PSW_CMD_ERASE_PAGE;
         end
      end else if (ctl_wdata[3:0] == `PSW_OP_ROW) begin
         op_valid = 1'b1;
         op_kind  = psw_pkg::PSW_CMD_PROG_ROW;
      end else if (ctl_wdata[3:0] == `PSW_OP_WORD) begin
         op_valid = 1'b1;
         op_kind  = psw_pkg::PSW_CMD_PROG_WORD;
      end
   end

   always_comb begin
      nxt_st           = st_ff;
      nxt_st.fl_start  = 1'b0;
      nxt_st.win_valid = 1'b0;
      nxt_st.tbl_done  = 1'b0;
      nxt_st.pm_rd     = 1'b0;
      nxt_st.pready    = apb_setup_acc;
      nxt_st.pslverr   = apb_setup_acc && !addr_ok;
      nxt_st.prdata    = '0;
      tmr_count        = '0;
      if (apb_setup_acc && !pwrite_i) begin
         case (paddr_i)
            `PSW_OFF_CORE_CTL: nxt_st.prdata[`PSW_VIS_BIT] = st_ff.vis_en;
            `PSW_OFF_WIN_PAGE: nxt_st.prdata[7:0] = st_ff.win_page;
            `PSW_OFF_TBL_PAGE: nxt_st.prdata[7:0] = st_ff.tbl_page;
            `PSW_OFF_FL_CTL: begin
               nxt_st.prdata[`PSW_WR_BIT]    = (st_ff.fst == psw_pkg::PSW_FL_BUSY);
               nxt_st.prdata[`PSW_WRITE_ENABLE_BIT_BIT]  = st_ff.write_enable_bit;
               nxt_st.prdata[`PSW_SEQUENCE_ERROR_FLAG_BIT] = st_ff.sequence_error_flag;
               nxt_st.prdata[`PSW_ERASE_BIT] = st_ff.erase;
               nxt_st.prdata[3:0]            = st_ff.op;
            end
            default: nxt_st.prdata = '0;
         endcase
      end
      if (apb_commit) begin
         // Unlock only survives back-to-back key writes
         if (paddr_i != `PSW_OFF_FL_KEY) begin
            nxt_st.key = psw_pkg::PSW_KEY_LOCKED;
         end
         case (paddr_i)
            `PSW_OFF_CORE_CTL: nxt_st.vis_en = pwdata_i[`PSW_VIS_BIT];
            `PSW_OFF_WIN_PAGE: nxt_st.win_page = pwdata_i[7:0];
            `PSW_OFF_TBL_PAGE: nxt_st.tbl_page = pwdata_i[7:0];
            `PSW_OFF_FL_KEY: begin
               if (pwdata_i[7:0] == `PSW_KEY_FIRST) begin
                  nxt_st.key = psw_pkg::PSW_KEY_HALF;
               end else if (st_ff.key == psw_pkg::PSW_KEY_HALF
                            && pwdata_i[7:0] == `PSW_KEY_SECOND) begin
                  nxt_st.key = psw_pkg::PSW_KEY_ARMED;
               end else begin
                  nxt_st.key = psw_pkg::PSW_KEY_LOCKED;
               end
            end
            `PSW_OFF_FL_CTL: begin
               if (st_ff.fst == psw_pkg::PSW_FL_IDLE) begin
                  nxt_st.write_enable_bit  = ctl_wdata[`PSW_WRITE_ENABLE_BIT_BIT];
                  nxt_st.erase = ctl_wdata[`PSW_ERASE_BIT];
                  nxt_st.op    = ctl_wdata[3:0];
                  if (ctl_wdata[`PSW_WR_BIT]) begin
                     if (st_ff.key == psw_pkg::PSW_KEY_ARMED && ctl_wdata[`PSW_WRITE_ENABLE_BIT_BIT]
                         && op_valid) begin
                        nxt_st.fst          = psw_pkg::PSW_FL_BUSY;
                        nxt_st.fl_start     = 1'b1;
                        nxt_st.fl_cmd.kind  = op_kind;
                        case (op_kind)
                           psw_pkg::PSW_CMD_ERASE_PAGE: begin
                              nxt_st.fl_cmd.addr = {st_ff.fl_cmd.addr[23:`PSW_PAGE_LSB],
                                                    `PSW_PAGE_LSB'(0)};
                              tmr_count = `PSW_OSC_CNT_W'(ERASE_OSC_CYCLES);
                           end
                           psw_pkg::PSW_CMD_PROG_ROW: begin
                              nxt_st.fl_cmd.addr = {st_ff.fl_cmd.addr[23:`PSW_ROW_LSB],
                                                    `PSW_ROW_LSB'(0)};
                              tmr_count = `PSW_OSC_CNT_W'(ROW_OSC_CYCLES);
                           end
                           default: begin
                              nxt_st.fl_cmd.addr = {st_ff.fl_cmd.addr[23:1], 1'b0};
                              tmr_count = `PSW_OSC_CNT_W'(WORD_OSC_CYCLES);
                           end
                        endcase
                     end else begin
                        nxt_st.sequence_error_flag = 1'b1;
                     end
                  end
               end
            end
            default: nxt_st.key = psw_pkg::PSW_KEY_LOCKED;
         endcase
      end
      if (tmr_done) begin
         nxt_st.fst   = psw_pkg::PSW_FL_IDLE;
         nxt_st.sequence_error_flag = 1'b0;
      end
      // Core port: accept in cycle 0, fetch (or buffer write for a table write) in cycle 1, answer in cycle 2
      case (st_ff.acc)
         psw_pkg::PSW_ACC_IDLE: begin
            if (take_tbl) begin
               nxt_st.acc       = tbl_req_i.write ? psw_pkg::PSW_ACC_TWR : psw_pkg::PSW_ACC_TRD;
               nxt_st.acc_addr  = {st_ff.tbl_page, tbl_req_i.ea};
               nxt_st.acc_high  = tbl_req_i.high;
               nxt_st.acc_byte  = tbl_req_i.byte_mode;
               nxt_st.acc_wdata = tbl_req_i.wdata;
               nxt_st.pm_rd     = !tbl_req_i.write;
               nxt_st.pm_raddr  = {st_ff.tbl_page, tbl_req_i.ea};
            end else if (take_win) begin
               nxt_st.acc      = psw_pkg::PSW_ACC_WIN;
               nxt_st.pm_rd    = 1'b1;
               nxt_st.pm_raddr = {1'b0, st_ff.win_page, win_req_i.ea[14:0]};
               if (win_req_i.rpt_active) begin
                  nxt_st.acc_extra = win_req_i.rpt_edge ? 2'h2 : 2'h0;
               end else begin
                  nxt_st.acc_extra = win_req_i.is_move ? 2'h1 : 2'h2;
               end
            end
         end
         psw_pkg::PSW_ACC_WIN: begin
            nxt_st.acc       = psw_pkg::PSW_ACC_IDLE;
            nxt_st.win_valid = 1'b1;
            nxt_st.win_data  = pm_rdata_i[15:0];
            nxt_st.win_extra = st_ff.acc_extra;
         end
         psw_pkg::PSW_ACC_TRD: begin
            nxt_st.acc      = psw_pkg::PSW_ACC_IDLE;
            nxt_st.tbl_done = 1'b1;
            if (st_ff.acc_high) begin
               nxt_st.tbl_rdata = (st_ff.acc_byte && st_ff.acc_addr[0]) ? 16'h0000
                                  : {8'h00, pm_rdata_i[23:16]};
            end else if (st_ff.acc_byte) begin
               nxt_st.tbl_rdata = {8'h00, st_ff.acc_addr[0] ? pm_rdata_i[15:8]
                                                            : pm_rdata_i[7:0]};
            end else begin
               nxt_st.tbl_rdata = pm_rdata_i[15:0];
            end
         end
         psw_pkg::PSW_ACC_TWR: begin
            nxt_st.acc         = psw_pkg::PSW_ACC_IDLE;
            nxt_st.tbl_done    = 1'b1;
            nxt_st.fl_cmd.addr = st_ff.acc_addr;
            // Index from the word address; software keeps one aligned row
            if (st_ff.acc_high) begin
               if (!(st_ff.acc_byte && st_ff.acc_addr[0])) begin
                  nxt_st.hold[st_ff.acc_addr[6:1]][23:16] = st_ff.acc_wdata[7:0];
               end
            end else if (st_ff.acc_byte) begin
               if (st_ff.acc_addr[0]) begin
                  nxt_st.hold[st_ff.acc_addr[6:1]][15:8] = st_ff.acc_wdata[7:0];
               end else begin
                  nxt_st.hold[st_ff.acc_addr[6:1]][7:0] = st_ff.acc_wdata[7:0];
               end
            end else begin
               nxt_st.hold[st_ff.acc_addr[6:1]][15:0] = st_ff.acc_wdata;
            end
         end
         default: nxt_st.acc = psw_pkg::PSW_ACC_IDLE;
      endcase
      // Buffers only change through the core port, which is closed while busy
      nxt_st.buf_q = st_ff.hold[fl_buf_idx_i];
      nxt_st.stall = (nxt_st.fst == psw_pkg::PSW_FL_BUSY)
                     || (nxt_st.acc != psw_pkg::PSW_ACC_IDLE);
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   psw_flash_timer u_timer (
      .clock_i   (clock_i),
      .rstn_i    (rstn_i),
      .frc_clk_i (frc_clk_i),
      .start_i   (nxt_st.fl_start),
      .count_i   (tmr_count),
      .done_o    (tmr_done)
   );

   assign pready_o      = st_ff.pready;
   assign pslverr_o     = st_ff.pslverr;
   assign prdata_o      = st_ff.prdata;
   assign pm_rd_o       = st_ff.pm_rd;
   assign pm_raddr_o    = st_ff.pm_raddr;
   assign win_valid_o   = st_ff.win_valid;
   assign win_data_o    = st_ff.win_data;
   assign win_extra_o   = st_ff.win_extra;
   assign tbl_done_o    = st_ff.tbl_done;
   assign tbl_rdata_o   = st_ff.tbl_rdata;
   assign stall_o       = st_ff.stall;
   assign fl_start_o    = st_ff.fl_start;
   assign fl_cmd_o      = st_ff.fl_cmd;
   assign fl_buf_data_o = st_ff.buf_q;
   assign fl_busy_o     = (st_ff.fst == psw_pkg::PSW_FL_BUSY);

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rstn_i);

   sequence s_win_take;
      take_win;
   endsequence
   sequence s_win_answer;
      stall_o && pm_rd_o ##1 win_valid_o;
   endsequence

   a_win_route: assert property (take_win |=> pm_raddr_o[23:15] == {1'b0, $past(st_ff.win_page)}
      && pm_raddr_o[14:0] == $past(win_req_i.ea[14:0])) else $error("window address");
   a_win_gate: assert property (acc_free && win_req_i.req && !tbl_req_i.req
      && !(win_req_i.ea[15] && st_ff.vis_en) |=> !pm_rd_o) else $error("window leak");
   a_win_low: assert property (win_valid_o |-> win_data_o == $past(pm_rdata_i[15:0]))
      else $error("window data");
   a_win_stretch: assert property (s_win_take |=> s_win_answer) else $error("window stretch");
   a_tbl_prio: assert property (acc_free && tbl_req_i.req |-> ##2 !win_valid_o && tbl_done_o)
      else $error("table priority");
   a_win_extra: assert property (take_win && !win_req_i.rpt_active && win_req_i.is_move
      |-> ##2 win_extra_o == 2'h1) else $error("move extra");
   a_rpt_mid: assert property (take_win && win_req_i.rpt_active && !win_req_i.rpt_edge
      |-> ##2 win_extra_o == 2'h0) else $error("repeat extra");
   a_tbl_addr: assert property (take_tbl && !tbl_req_i.write |=> pm_rd_o
      && pm_raddr_o == {$past(st_ff.tbl_page), $past(tbl_req_i.ea)}) else $error("table addr");
   a_fl_stall: assert property (fl_start_o |-> stall_o && fl_busy_o) else $error("no stall");
   a_wr_clear: assert property (tmr_done |=> !fl_busy_o && !st_ff.sequence_error_flag) else $error("end");
   a_no_unlock: assert property (apb_commit && paddr_i == `PSW_OFF_FL_CTL
      && st_ff.key != psw_pkg::PSW_KEY_ARMED && !fl_busy_o && pwdata_i[`PSW_WR_BIT]
      |=> !fl_start_o && st_ff.sequence_error_flag) else $error("started locked");

endmodule : psw_top

// ==== design/psw_params.svh ====
`ifndef PSW_PARAMS_SVH
`define PSW_PARAMS_SVH

// Register byte offsets on APB
`define PSW_OFF_CORE_CTL    8'h00
`define PSW_OFF_WIN_PAGE    8'h04
`define PSW_OFF_TBL_PAGE    8'h08
`define PSW_OFF_FL_CTL      8'h0c
`define PSW_OFF_FL_KEY      8'h10
`define PSW_PADDR_W         8

// Field positions
`define PSW_VIS_BIT         2
`define PSW_WR_BIT          15
`define PSW_WRITE_ENABLE_BIT_BIT        14
`define PSW_SEQUENCE_ERROR_FLAG_BIT       13
`define PSW_ERASE_BIT       6
`define PSW_EA_MSB          15
`define PSW_ROW_LSB         7
`define PSW_PAGE_LSB        10

// Operation codes and key values
`define PSW_OP_PAGE_ERASE   4'h2
`define PSW_OP_ROW          4'h1
`define PSW_OP_WORD         4'h3
`define PSW_KEY_FIRST       8'h55
`define PSW_KEY_SECOND      8'haa

// Geometry and oscillator cycle counts
`define PSW_ROW_WORDS       64
`define PSW_ROW_OSC_CYCLES  11064
`define PSW_ERASE_OSC_CYCLES 11064
`define PSW_WORD_OSC_CYCLES 200
`define PSW_OSC_CNT_W       16

`endif

// ==== design/psw_pkg.sv ====
`include "psw_params.svh"

package psw_pkg;

   typedef enum logic {
      PSW_FL_IDLE = 1'b0,
      PSW_FL_BUSY = 1'b1
   } psw_fl_state_t;

   typedef enum logic [1:0] {
      PSW_KEY_LOCKED = 2'b00,
      PSW_KEY_HALF   = 2'b01,
      PSW_KEY_ARMED  = 2'b11
   } psw_key_t;

   typedef enum logic [1:0] {
      PSW_ACC_IDLE = 2'b00,
      PSW_ACC_WIN  = 2'b01,
      PSW_ACC_TRD  = 2'b11,
      PSW_ACC_TWR  = 2'b10
   } psw_acc_t;

   typedef enum logic [1:0] {
      PSW_CMD_ERASE_PAGE = 2'b00,
      PSW_CMD_PROG_ROW   = 2'b01,
      PSW_CMD_PROG_WORD  = 2'b11
   } psw_cmd_kind_t;

   typedef struct packed {
      psw_cmd_kind_t kind;
      logic [23:0]   addr;
   } psw_fl_cmd_t;

   typedef struct packed {
      logic        req;
      logic [15:0] ea;
      logic        is_move;
      logic        rpt_active;
      logic        rpt_edge;
   } psw_win_req_t;

   typedef struct packed {
      logic        req;
      logic        write;
      logic        high;
      logic        byte_mode;
      logic [15:0] ea;
      logic [15:0] wdata;
   } psw_tbl_req_t;

   typedef struct packed {
      logic                        sync1;
      logic                        sync2;
      logic                        last;
      logic                        run;
      logic [`PSW_OSC_CNT_W-1:0]   cnt;
      logic                        done;
   } psw_tmr_state_t;

   typedef struct packed {
      logic                             pready;
      logic                             pslverr;
      logic [31:0]                      prdata;
      logic                             vis_en;
      logic [7:0]                       win_page;
      logic [7:0]                       tbl_page;
      logic                             write_enable_bit;
      logic                             sequence_error_flag;
      logic                             erase;
      logic [3:0]                       op;
      psw_fl_state_t                    fst;
      psw_key_t                         key;
      logic                             fl_start;
      psw_fl_cmd_t                      fl_cmd;
      psw_acc_t                         acc;
      logic [23:0]                      acc_addr;
      logic                             acc_high;
      logic                             acc_byte;
      logic [15:0]                      acc_wdata;
      logic [1:0]                       acc_extra;
      logic                             pm_rd;
      logic [23:0]                      pm_raddr;
      logic                             win_valid;
      logic [15:0]                      win_data;
      logic [1:0]                       win_extra;
      logic                             tbl_done;
      logic [15:0]                      tbl_rdata;
      logic                             stall;
      logic [23:0]                      buf_q;
      logic [`PSW_ROW_WORDS-1:0][23:0]  hold;
   } psw_state_t;

endpackage : psw_pkg

// ==== design/psw_flash_timer.sv ====
`timescale 1ns/1ps
`include "psw_params.svh"

module psw_flash_timer (
   input  wire logic                      clock_i,
   input  wire logic                      rstn_i,
   input  wire logic                      frc_clk_i,
   input  wire logic                      start_i,
   input  wire logic [`PSW_OSC_CNT_W-1:0] count_i,
   output logic                           done_o
);

   psw_pkg::psw_tmr_state_t st_ff;
   psw_pkg::psw_tmr_state_t nxt_st;

   // Oscillator edges counted after a two-stage synchroniser; tuning already
   // shifts the oscillator rate, so the duration follows it
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.sync1 = frc_clk_i;
      nxt_st.sync2 = st_ff.sync1;
      nxt_st.last  = st_ff.sync2;
      nxt_st.done  = 1'b0;
      if (start_i) begin
         nxt_st.run = 1'b1;
         nxt_st.cnt = count_i;
      end else if (st_ff.run && st_ff.sync2 && !st_ff.last) begin
         if (st_ff.cnt <= `PSW_OSC_CNT_W'(1)) begin
            nxt_st.run  = 1'b0;
            nxt_st.cnt  = '0;
            nxt_st.done = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - `PSW_OSC_CNT_W'(1);
         end
      end
   end

   always_ff @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign done_o = st_ff.done;

endmodule : psw_flash_timer

// ==== testbench/psw_pm_model.sv ====
`timescale 1ns/1ps
module psw_pm_model (
   input  wire logic        clock_i,
   input  wire logic        pm_rd_i,
   input  wire logic [23:0] pm_raddr_i,
   output logic [23:0]      pm_rdata_o
);
   logic [23:0] last_ff = 24'h000000;
   always_ff @(posedge clock_i) begin
      last_ff <= pm_rdata_o;
   end
   // Upper byte all ones on reads so stray execution does nothing harmful
   always_comb begin
      if (pm_rd_i) begin
         pm_rdata_o = {8'hff, pm_raddr_i[15:0] ^ 16'h1234};
      end else begin
         pm_rdata_o = ~last_ff;
      end
   end
endmodule : psw_pm_model

// ==== testbench/psw_top_bench.sv ====
`timescale 1ns/1ps
`include "psw_params.svh"
module psw_top_bench;
   logic                  clock_i = 1'b0;
   logic                  rstn_i = 1'b0;
   logic                  frc_clk_i = 1'b0;
   logic                  psel_i = 1'b0;
   logic                  penable_i = 1'b0;
   logic                  pwrite_i = 1'b0;
   logic [7:0]            paddr_i = 8'h00;
   logic [31:0]           pwdata_i = 32'h00000000;
   psw_pkg::psw_win_req_t win_req_i = '0;
   psw_pkg::psw_tbl_req_t tbl_req_i = '0;
   logic [5:0]            fl_buf_idx_i = 6'h00;
   logic                  pready_o, pslverr_o, pm_rd_o, win_valid_o;
   logic                  tbl_done_o, stall_o, fl_start_o, fl_busy_o;
   logic [31:0]           prdata_o, rd;
   logic [23:0]           pm_raddr_o, pm_rdata_i, fl_buf_data_o;
   logic [15:0]           win_data_o, tbl_rdata_o;
   logic [1:0]            win_extra_o;
   logic                  rerr;
   psw_pkg::psw_fl_cmd_t  fl_cmd_o;
   logic [7:0]            page = 8'h5b;
   int                    error_cnt = 0;
   int                    check_count = 0;

   always #2 clock_i = ~clock_i;
   // Period unrelated to the system clock
   always #68.3 frc_clk_i = ~frc_clk_i;

   psw_top #(.ROW_OSC_CYCLES(3), .ERASE_OSC_CYCLES(3), .WORD_OSC_CYCLES(3)) dut_u (
      .clock_i, .rstn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pready_o,
      .pslverr_o, .prdata_o, .win_req_i, .tbl_req_i, .pm_rdata_i, .pm_rd_o, .pm_raddr_o,
      .win_valid_o, .win_data_o, .win_extra_o, .tbl_done_o, .tbl_rdata_o, .stall_o,
      .frc_clk_i, .fl_start_o, .fl_cmd_o, .fl_buf_idx_i, .fl_buf_data_o, .fl_busy_o);
   psw_pm_model pm_u (.clock_i, .pm_rd_i(pm_rd_o), .pm_raddr_i(pm_raddr_o),
      .pm_rdata_o(pm_rdata_i));

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      do begin
         @(posedge clock_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      // A slave that never answers counts against the run
      if (pready_o !== 1'b1) error_cnt++;
      rd = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
   endtask : apb

   task automatic win(input logic [15:0] ea, input logic mv, ra, re, ans, input logic [1:0] xe);
      int k;
      k = 0;
      win_req_i <= '{1'b1, ea, mv, ra, re};
      @(posedge clock_i);
      win_req_i.req <= 1'b0;
      do begin
         @(posedge clock_i);
         k++;
      end while (win_valid_o !== 1'b1 && k < 4);
      if (ans) begin
         chk("win_lat", 2, k);
         chk("win_addr", {1'b0, page, ea[14:0]}, pm_raddr_o);
         chk("win_data", {page[0], ea[14:0]} ^ 16'h1234, win_data_o);
         chk("win_extra", xe, win_extra_o);
      end else begin
         chk("win_none", 4, k);
      end
   endtask : win

   task automatic tbl(input logic w, h, b, input logic [15:0] ea, wd, input logic [15:0] xr);
      int k;
      k = 0;
      tbl_req_i <= '{1'b1, w, h, b, ea, wd};
      @(posedge clock_i);
      tbl_req_i.req <= 1'b0;
      do begin
         @(posedge clock_i);
         k++;
      end while (tbl_done_o !== 1'b1 && k < 4);
      chk("tbl_lat", 2, k);
      if (!w) chk("tbl_rdata", xr, tbl_rdata_o);
      if (!w) chk("tbl_addr", {8'h01, ea}, pm_raddr_o);
   endtask : tbl

   task automatic fop(input logic [15:0] c, input logic vd, v, input logic [1:0] kd,
                      input logic [23:0] ad);
      int k;
      k = 0;
      apb(1'b1, `PSW_OFF_FL_KEY, 32'h55);
      if (vd) apb(1'b1, `PSW_OFF_WIN_PAGE, page);
      apb(1'b1, `PSW_OFF_FL_KEY, 32'haa);
      apb(1'b1, `PSW_OFF_FL_CTL, c);
      chk("fl_start", v, fl_start_o);
      if (v) begin
         chk("fl_cmd", {kd, ad}, fl_cmd_o);
         chk("stall", 1, stall_o);
         if (kd == 2'b01) chk("buf_hold", 24'hc3beef, fl_buf_data_o);
         do begin
            @(posedge clock_i);
            k++;
         end while (fl_busy_o === 1'b1 && k < 300);
         chk("fl_dur", 1, k > 68 && k < 300);
         chk("stall_end", 0, stall_o);
      end
      apb(1'b0, `PSW_OFF_FL_CTL, 0);
      chk("ctl_wr", 0, rd[15]);
      chk("ctl_err", !v, rd[13]);
   endtask : fop

   task automatic t_regs();
      logic [7:0] offs [5] = '{`PSW_OFF_CORE_CTL, `PSW_OFF_WIN_PAGE, `PSW_OFF_TBL_PAGE,
                               `PSW_OFF_FL_CTL, `PSW_OFF_FL_KEY};
      foreach (offs[i]) begin
         apb(1'b0, offs[i], 0);
         chk("reset_val", 0, rd);
         chk("slverr", 0, rerr);
      end
      apb(1'b0, 8'h20, 0);
      chk("unmapped", 1, rerr);
   endtask : t_regs

   initial begin
      repeat (4) @(posedge clock_i);
      rstn_i <= 1'b1;
      @(posedge clock_i);
      t_regs();
      apb(1'b1, `PSW_OFF_CORE_CTL, 32'h4);
      apb(1'b1, `PSW_OFF_WIN_PAGE, page);
      win(16'h8abc, 1, 0, 0, 1, 2'd1);
      win(16'hfffe, 0, 0, 0, 1, 2'd2);
      win(16'h8000, 0, 1, 0, 1, 2'd0);
      win(16'h9000, 1, 1, 1, 1, 2'd2);
      win(16'h7fff, 0, 0, 0, 0, 2'd0);
      apb(1'b1, `PSW_OFF_CORE_CTL, 0);
      win(16'h8abc, 0, 0, 0, 0, 2'd0);
      apb(1'b1, `PSW_OFF_TBL_PAGE, 8'h01);
      tbl(0, 0, 0, 16'h0456, 0, 16'h0456 ^ 16'h1234);
      tbl(0, 1, 0, 16'h0456, 0, 16'h00ff);
      tbl(0, 0, 1, 16'h0457, 0, 16'h0016);
      tbl(1, 0, 0, 16'h1234, 16'hbeef, 0);
      tbl(1, 1, 0, 16'h1234, 16'h00c3, 0);
      fl_buf_idx_i <= 6'h1a;
      repeat (2) @(posedge clock_i);
      chk("buf", 24'hc3beef, fl_buf_data_o);
      fop(16'h8001, 0, 0, 2'b00, 0);
      fop(16'hc041, 0, 0, 2'b00, 0);
      fop(16'hc001, 1, 0, 2'b00, 0);
      // Start aligns the stored address, so the finest alignment goes first
      fop(16'hc003, 0, 1, 2'b11, 24'h011234);
      fop(16'hc001, 0, 1, 2'b01, 24'h011200);
      fop(16'hc042, 0, 1, 2'b00, 24'h011000);
      give_verdict();
   end

   initial begin
      #60000;
      error_cnt++;
      give_verdict();
   end
endmodule : psw_top_bench
